//--- eid_chk.sv
// concurrent checks on the ports of the extended instruction decoder
// assumes it is bound to eid_decode and sees one clock domain
`timescale 1ns/1ps
module eid_chk #(parameter logic [11:0] LO = 12'hfe0, parameter logic [11:0] HI = 12'hfef) (
  // control and stream
  input wire logic sys_clk_in, reset_n_in, ext_enable_in, instr_valid_in, instr_ready_out,
  input wire logic byte_op_in, access_bit_in, flush_out,
  input wire logic [15:0] instr_word_in,
  // core state and memory
  input wire logic [7:0] working_register_in, pc_high_latch_in, file_addr_in, rd_data_in,
  input wire logic [4:0] pc_upper_latch_in,
  input wire logic [20:0] top_of_return_stack_in, next_pc_in,
  input wire logic [11:0] eff_addr_out, rd_addr_out,
  input wire logic [35:0] pointers_out,
  input wire eid_pkg::eid_wr_type mem_wr_out,
  input wire eid_pkg::eid_pc_type pc_out,
  input wire eid_pkg::eid_stack_type stack_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // decoded taken words
  wire tk = instr_valid_in && instr_ready_out && ext_enable_in;
  wire [15:0] w = instr_word_in;
  wire ret = tk && w[15:6] == 10'h3a3;
  wire addp = tk && w[15:8] == 8'he8 && w[7:6] != 2'h3;
  wire mv1 = tk && w[15:8] == 8'heb;
  wire sec = tk && w[15:12] == 4'hf;
  logic mv_r;
  // remembers a pending move first word, so a lone prefix word is told apart
  always_ff @(posedge sys_clk_in) mv_r <= reset_n_in && (tk ? mv1 : mv_r);
  AST_ADD: assert property (addp |=> pointers_out[12*$past(w[7:6]) +: 12] ==
    $past(pointers_out[12*w[7:6] +: 12]) + $past(w[5:0])) else $error("pointer add wrong");
  AST_RET: assert property (ret |=> pc_out.load && stack_out.pop && flush_out &&
    pc_out.value == $past(top_of_return_stack_in) &&
    pointers_out[35:24] == $past(pointers_out[35:24]) + $past(w[5:0])) else $error("return bad");
  AST_PAD: assert property (ret |=> !instr_ready_out ##1 instr_ready_out && !pc_out.load)
    else $error("padding cycle wrong");
  AST_SEL: assert property (ret |=> $stable(pointers_out[23:0])) else $error("select 3 bad");
  AST_CALL: assert property (tk && w == 16'h0014 |=> pc_out.load && stack_out.push &&
    pc_out.value == $past({pc_upper_latch_in, pc_high_latch_in, working_register_in}) &&
    stack_out.value == $past(next_pc_in) && flush_out) else $error("call bad");
  AST_SRC: assert property (mv1 |=> rd_addr_out == $past(pointers_out[35:24]) +
    $past(w[6:0])) else $error("move source bad");
  AST_DST: assert property (sec && mv_r |=> mem_wr_out.en &&
    mem_wr_out.addr == $past(w[11:0])) else $error("move dest bad");
  AST_ZERO: assert property (sec && mv_r && rd_addr_out >= LO && rd_addr_out <= HI |=>
    mem_wr_out.data == 8'h00) else $error("indirect source not zero");
  AST_IDX: assert property (byte_op_in && ext_enable_in && !access_bit_in &&
    file_addr_in <= 8'h5f |=> eff_addr_out == $past(pointers_out[35:24]) + $past(file_addr_in))
    else $error("indexed address bad");
  AST_LONE: assert property (sec && !mv_r |=> !mem_wr_out.en && !pc_out.load &&
    $stable(pointers_out)) else $error("lone prefix acted");
endmodule

//--- eid_decode.sv
// extended instruction decoder and executor with its three indirect pointers
// assumes a data memory that answers a read one clock after the address
`timescale 1ns/1ps
module eid_decode #(
  parameter logic [11:0] INDIRECT_LO = 12'hfe0,
  parameter logic [11:0] INDIRECT_HI = 12'hfef
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // instruction stream
  input wire logic ext_enable_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_word_in,
  output logic instr_ready_out,
  // core state read by the block
  input wire logic [7:0] working_register_in,
  input wire logic [7:0] pc_high_latch_in,
  input wire logic [4:0] pc_upper_latch_in,
  input wire logic [20:0] top_of_return_stack_in,
  input wire logic [20:0] next_pc_in,
  // byte-oriented operand address translation
  input wire logic byte_op_in,
  input wire logic access_bit_in,
  input wire logic [7:0] file_addr_in,
  output logic [11:0] eff_addr_out,
  // data memory
  output logic [11:0] rd_addr_out,
  input wire logic [7:0] rd_data_in,
  output eid_pkg::eid_wr_type mem_wr_out,
  // control to the core
  output eid_pkg::eid_pc_type pc_out,
  output eid_pkg::eid_stack_type stack_out,
  output logic flush_out,
  output logic [35:0] pointers_out
);
  // sequencing overview, one clock edge per instruction cycle:
  // - idle: every opcode of the extended set may be taken
  // - nop: padding cycle after add-and-return or call via working
  // - move: waiting for the destination word of an indexed move
  //
  // add to pointer finishes in the taking cycle; the sum lands on
  // the next edge and the stream keeps flowing with no stall
  //
  // add-and-return and call via working both redirect fetch, so the
  // word after them is stale; ready drops for one cycle so that the
  // core can refill from the new pc while flush marks the idle slot
  //
  // the indexed move needs two words; the first issues the source
  // read, the second carries the destination and triggers the write
  // one edge later, when the read data has had a cycle to settle
  //
  // decodes are gated by idle so that a destination word whose low
  // bits happen to look like another opcode never acts as one
  //
  // limitations a user must know:
  // - pointers are only written here; the core has no write path
  // - pointer sums wrap silently at twelve bits
  // - the move and the translation read pointer two as it stood
  //   before any update made in the same cycle
  // - status flags do not exist in this block, so none can change
  // - the indirect register window is a parameter, not decoded from
  //   the full special register map, trading accuracy for size
  // - the high access half maps to the top bank, a fixed choice
  //
  // pc load, stack push and pop and flush are registered pulses, so the core sees
  // clean single-cycle requests at the cost of one cycle of latency
  //
  // state and pipeline registers
  eid_pkg::eid_state_type state_r, state_nxt;
  logic [11:0] ptr_r [3];
  logic [11:0] rd_addr_r;
  logic src_zero_r;
  logic [11:0] eff_addr_r;
  eid_pkg::eid_wr_type wr_r;
  eid_pkg::eid_pc_type pc_r;
  eid_pkg::eid_stack_type stack_r;
  logic flush_r;

  // decode of the word taken this cycle
  wire take = instr_valid_in && instr_ready_out;
  wire [1:0] sel = instr_word_in[eid_pkg::SEL_HI:eid_pkg::SEL_LO];
  wire [11:0] lit = {6'h00, instr_word_in[eid_pkg::LIT_HI:0]};
  // the second move word must never decode as a fresh opcode
  wire in_idle = state_r == eid_pkg::ST_IDLE;
  wire is_add = take && in_idle && ext_enable_in &&
                instr_word_in[15:8] == eid_pkg::OPC_ADD_PTR;
  wire is_add_ptr = is_add && sel != eid_pkg::SEL_RETURN; // [RULE1]
  wire is_add_ret = is_add && sel == eid_pkg::SEL_RETURN; // [RULE4]
  wire is_call_via_working = take && in_idle && ext_enable_in && instr_word_in == eid_pkg::OPC_CALL_VIA_WORKING;
  wire is_move = take && in_idle && ext_enable_in &&
                 instr_word_in[15:8] == eid_pkg::OPC_MOVE;
  // a second word reached in idle falls through every decode above
  wire is_second = take && state_r == eid_pkg::ST_MOVE; // [RULE10]
  wire [11:0] src_addr = ptr_r[2] + {5'h00, instr_word_in[eid_pkg::OFS_HI:0]}; // [RULE6]
  wire src_indirect = src_addr >= INDIRECT_LO && src_addr <= INDIRECT_HI;
  wire [11:0] add_sum = ptr_r[is_add_ret ? eid_pkg::SEL_TWO : sel] + lit;

  // literal-offset indexing for low access-bank operands
  wire use_index = ext_enable_in && !access_bit_in && file_addr_in <= eid_pkg::INDEX_LIMIT;
  wire [11:0] idx_addr = ptr_r[2] + {4'h0, file_addr_in};
  wire [11:0] acc_addr = (file_addr_in <= eid_pkg::INDEX_LIMIT) ? {4'h0, file_addr_in}
                         : {eid_pkg::ACCESS_HI_BANK, file_addr_in};

  // handshake is combinational: only the padding cycle stalls the stream
  assign instr_ready_out = state_r != eid_pkg::ST_NOP;

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      eid_pkg::ST_IDLE: begin
        if (is_add_ret || is_call_via_working) begin
          state_nxt = eid_pkg::ST_NOP; // [RULE3] [RULE5]
        end else if (is_move) begin
          state_nxt = eid_pkg::ST_MOVE; // [RULE7]
        end
      end
      eid_pkg::ST_NOP: state_nxt = eid_pkg::ST_IDLE;
      eid_pkg::ST_MOVE: begin
        if (take) begin
          state_nxt = eid_pkg::ST_IDLE;
        end
      end
      default: state_nxt = eid_pkg::ST_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      state_r <= eid_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // pointer updates; no status flag is touched by any of these
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      ptr_r[0] <= eid_pkg::PTR_RESET;
      ptr_r[1] <= eid_pkg::PTR_RESET;
      ptr_r[2] <= eid_pkg::PTR_RESET;
    end else if (is_add_ptr) begin
      ptr_r[sel] <= add_sum; // [RULE1]
    end else if (is_add_ret) begin
      ptr_r[2] <= add_sum; // [RULE2]
    end
  end

  // source read issued with the first move word
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rd_addr_r <= 12'h000;
      src_zero_r <= 1'b0;
    end else if (is_move) begin
      rd_addr_r <= src_addr; // [RULE6]
      src_zero_r <= src_indirect; // [RULE8]
    end
  end

  // destination write with the second move word
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      wr_r <= '0;
    end else begin
      wr_r.en <= is_second;
      if (is_second) begin
        wr_r.addr <= instr_word_in[11:0]; // [RULE7]
        wr_r.data <= src_zero_r ? eid_pkg::MOVE_ZERO : rd_data_in; // [RULE8]
      end
    end
  end

  // program counter and stack requests, one-cycle pulses
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      pc_r <= '0;
      stack_r <= '0;
    end else begin
      pc_r.load <= is_add_ret || is_call_via_working;
      stack_r.pop <= is_add_ret; // [RULE2]
      stack_r.push <= is_call_via_working; // [RULE5]
      if (is_add_ret) begin
        pc_r.value <= top_of_return_stack_in; // [RULE2]
      end else if (is_call_via_working) begin
        pc_r.value <= {pc_upper_latch_in, pc_high_latch_in, working_register_in}; // [RULE5]
        stack_r.value <= next_pc_in; // [RULE5]
      end
    end
  end

  // flush marks the padding cycle while fetch restarts at the new pc
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      flush_r <= 1'b0;
    end else begin
      flush_r <= is_add_ret || is_call_via_working; // [RULE3]
    end
  end

  // operand address, registered: uses pointer two as it stands this cycle
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      eff_addr_r <= 12'h000;
    end else if (byte_op_in) begin
      eff_addr_r <= use_index ? idx_addr : acc_addr; // [RULE9]
    end
  end

  assign rd_addr_out = rd_addr_r;
  assign mem_wr_out = wr_r;
  assign pc_out = pc_r;
  assign stack_out = stack_r;
  assign flush_out = flush_r;
  assign eff_addr_out = eff_addr_r;
  assign pointers_out = {ptr_r[2], ptr_r[1], ptr_r[0]};
endmodule

//--- eid_pkg.sv
// constants, types and state codes for the extended instruction decoder
// assumes one clock edge per instruction cycle and a core that owns fetch
//
// Contract
// RULE1: add literal to selected pointer, flags untouched
// RULE2: add-and-return adds to pointer two, pops stack
// RULE3: add-and-return takes two cycles, second idle
// RULE4: select value three means add-and-return
// RULE5: call via working register: push, load pc
// RULE6: indexed move source is pointer two plus offset
// RULE7: move destination 12-bit absolute, two words
// RULE8: indirect register source moves zero instead
// RULE9: low access-bank addresses use literal-offset indexing
// RULE10: lone second-word prefix executes as no-op
package eid_pkg;
  // widths
  localparam int ADDR_W = 12;
  localparam int PC_W = 21;
  localparam int DATA_W = 8;
  // opcode patterns
  localparam logic [7:0] OPC_ADD_PTR = 8'he8;
  localparam logic [7:0] OPC_MOVE = 8'heb;
  localparam logic [15:0] OPC_CALL_VIA_WORKING = 16'h0014;
  localparam logic [3:0] OPC_SECOND = 4'hf;
  // field positions
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int LIT_HI = 5;
  localparam int OFS_HI = 6;
  localparam int BIT_OFS_ZERO = 7;
  localparam logic [1:0] SEL_RETURN = 2'h3;
  localparam logic [1:0] SEL_TWO = 2'h2;
  // access bank split and base of the upper access half
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  // pointer reset value and the byte moved from an indirect source
  localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
  localparam logic [DATA_W-1:0] MOVE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_NOP = 2'b01,
    ST_MOVE = 2'b10
  } eid_state_type;

  // program counter request to the core
  typedef struct packed {
    logic load;
    logic [PC_W-1:0] value;
  } eid_pc_type;

  // return stack request
  typedef struct packed {
    logic push;
    logic pop;
    logic [PC_W-1:0] value;
  } eid_stack_type;

  // data memory write
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } eid_wr_type;
endpackage

//--- eid_tb.sv
// random instruction mix against an integer model of the decoder
// assumes eid_pkg, eid_decode and eid_chk are compiled first
`timescale 1ns/1ps
module testbench;
  localparam logic [11:0] LO = 12'h800; // wide range so zero moves are common
  localparam logic [11:0] HI = 12'hbff;
  logic sys_clk_in = 0, reset_n_in = 0, ext_enable_in = 0, instr_valid_in = 0;
  logic byte_op_in = 0, access_bit_in = 0, instr_ready_out, flush_out, ret, cw, mv;
  logic [15:0] instr_word_in = 0, w, r;
  logic [7:0] working_register_in = 0, pc_high_latch_in = 0, file_addr_in = 0, rd_data_in = 0;
  logic [4:0] pc_upper_latch_in = 0;
  logic [20:0] top_of_return_stack_in = 0, next_pc_in = 0;
  logic [11:0] eff_addr_out, rd_addr_out, xe, src, w2, p[3];
  logic [35:0] pointers_out;
  eid_pkg::eid_wr_type mem_wr_out;
  eid_pkg::eid_pc_type pc_out;
  eid_pkg::eid_stack_type stack_out;
  int seed = 45602, n_errors = 0, check_count = 0, k;
  eid_decode #(.INDIRECT_LO(LO), .INDIRECT_HI(HI)) uut (.*);
  always #5 sys_clk_in = ~sys_clk_in;
  task automatic chk(input logic [47:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, well beyond the expected run
  initial begin
    #200000;
    n_errors++;
    conclude();
  end
  // main sequence: reset, then random words with fresh core values each step
  initial begin
    p = '{default: 12'h000};
    repeat (8) @(posedge sys_clk_in);
    reset_n_in <= 1;
    repeat (2000) begin
      k = {$random(seed)} % 5;
      r = 16'($random(seed));
      w2 = 12'($random(seed));
      w = k == 0 ? {8'he8, r[7:0]} : k == 1 ? 16'h0014 : k == 2 ? {4'hf, r[11:0]} :
        k == 3 ? {9'h1d6, r[6:0]} : {1'b0, r[14:0]};
      @(posedge sys_clk_in);
      instr_valid_in <= 1;
      instr_word_in <= w;
      ext_enable_in <= {$random(seed)} % 8 != 0;
      {working_register_in, pc_high_latch_in, pc_upper_latch_in} <= 21'($random(seed));
      {top_of_return_stack_in, rd_data_in} <= 29'($random(seed));
      next_pc_in <= 21'($random(seed));
      {byte_op_in, access_bit_in, file_addr_in} <= 10'($random(seed));
      #1;
      // model: translation and source use the pointer before this step's add
      xe = file_addr_in > 8'h5f ? {4'hf, file_addr_in} :
        ext_enable_in && !access_bit_in ? p[2] + file_addr_in : {4'h0, file_addr_in};
      src = p[2] + w[6:0];
      ret = ext_enable_in && w[15:6] == 10'h3a3;
      cw = ext_enable_in && w == 16'h0014;
      mv = ext_enable_in && k == 3;
      if (ext_enable_in && w[15:8] == 8'he8) p[ret ? 2 : w[7:6]] += w[5:0];
      @(posedge sys_clk_in);
      if (k == 3) instr_word_in <= {4'hf, w2};
      else instr_valid_in <= 0;
      #1;
      chk(pointers_out, {p[2], p[1], p[0]});
      if (byte_op_in) chk(eff_addr_out, xe);
      chk({pc_out.load, stack_out.pop, stack_out.push, flush_out, instr_ready_out,
        mem_wr_out.en}, {ret | cw, ret, cw, ret | cw, !(ret | cw), 1'b0});
      if (ret) chk(pc_out.value, top_of_return_stack_in);
      if (cw) chk({pc_out.value, stack_out.value}, {pc_upper_latch_in, pc_high_latch_in,
        working_register_in, next_pc_in});
      if (mv) chk(rd_addr_out, src);
      if (k == 3) begin
        @(posedge sys_clk_in);
        instr_valid_in <= 0;
        #1;
        chk({mem_wr_out.en, mem_wr_out.addr}, {mv, mv ? w2 : mem_wr_out.addr});
        if (mv) chk(mem_wr_out.data, src >= LO && src <= HI ? 8'h00 : rd_data_in);
      end
    end
    conclude();
  end
endmodule
bind eid_decode eid_chk #(.LO(INDIRECT_LO), .HI(INDIRECT_HI)) chk_i (.*);
